//--- hw/bmsc_boot_sleep_ctrl.sv
// boot strap sampling, pin setup, cpu clock scaling and sleep control
//
// Operation
// R1 - sample clock rate strap after reset
// R2 - boot mode from pins 31:30 at release
// R3 - 00 parallel, 01 serial, 10 spi, 11 alone
// R4 - boot procedure lasts at most 3 ms
// R5 - straps read only during boot, then gpio
// R6 - coprocessor: enable selected port, wait idle
// R7 - host loads only after boot time
// R8 - port speeds: 16 bit, 2M baud, 2Mb/s
// R9 - standalone: eeprom pins out, debug uart
// R10 - pin 29 picks otg peripheral or host
// R11 - other usb ports peripheral, rest inputs
// R12 - cpu clock divider without touching peripherals
// R13 - sleep entered by sleep enable bit
// R14 - sleep keeps gpio, drives memory address low
// R15 - sleep stops crystal, pll, booster, transceivers
// R16 - cpu suspended until enabled wakeup event
// R17 - firmware should stop charge pump first
// R18 - resume within 200 us after wakeup
// R19 - reset held sixteen 12 MHz cycles
// R20 - wake restarts crystal, pll; cpu gated

`timescale 1ns/1ns
`include "bmsc_regs.svh"

module bmsc_boot_sleep_ctrl #(
    parameter int BOOT_CYCLES = `BMSC_BOOT_CYC, // boot time in cycles
    parameter int PLL_CYCLES = `BMSC_PLL_CYC, // pll lock time in cycles
    parameter int DIV_W = 4, // cpu speed field width
    parameter int WAKE_W = 8 // number of wakeup sources
) (
    input wire logic sys_clk, // 50 MHz system clock
    input wire logic rst, // async reset, active high
    input wire logic activeLowResetPin_n, // external reset pin, low = reset
    input wire logic clockRateStrap, // clock source select strap
    input wire logic [31:0] gpioIn, // gpio pin levels
    input wire logic [31:0] appGpioOe_n, // application gpio enables, low=drive
    input wire logic [31:0] appGpioOut, // application gpio output values
    input wire logic [DIV_W-1:0] cpuSpeedWr, // cpu speed write value
    input wire logic cpuSpeedWe, // cpu speed write strobe
    input wire logic sleepEnableWr, // power control sleep bit value
    input wire logic pwrCtrlWe, // power control write strobe
    input wire logic [WAKE_W-1:0] wakeEnable, // wakeup source enables
    input wire logic [WAKE_W-1:0] wakeEvent, // wakeup source events
    input wire logic pumpEnableIn, // firmware charge pump request
    input wire logic portActivity, // host started talking on port
    input wire logic [15:0] memAddrIn, // cpu external memory address
    output bmsc_pkg::bmsc_mode_e bootMode, // latched boot mode
    output logic clockRateSel, // latched clock rate strap
    output logic bootDone, // boot procedure finished
    output logic loadReady, // code load may begin
    output logic parallelHostPortEn, // parallel host port enabled
    output logic fastSerialPortEn, // fast serial port enabled
    output logic spiSlavePortEn, // spi slave port enabled
    output logic coprocIdle, // waiting for host to talk
    output logic [31:0] gpioOe_n, // gpio output enables, low=drive
    output logic [31:0] gpioOut, // gpio output values
    output logic debugUartEn, // debug uart on pins 28:27
    output logic otgIsPeripheral, // first otg port role
    output logic [2:0] otherPortsPeripheral, // remaining usb port roles
    output logic [DIV_W-1:0] cpuSpeedDiv, // cpu clock divider
    output logic sleepActive, // asleep
    output logic cpuSuspended, // cpu clock gated
    output logic crystalDriveEn, // crystal drive output on
    output logic pllEn, // pll on
    output logic boosterEn, // supply booster on
    output logic transceiverEn, // usb transceivers on
    output logic pumpEn, // otg charge pump on
    output logic [15:0] memAddrOut // external memory address pins
);
    import bmsc_pkg::*;

    localparam int BW = $clog2(BOOT_CYCLES + 1);
    localparam int PW = $clog2(PLL_CYCLES + 1);
    localparam int TW = (BW > PW) ? BW : PW;

    // refuse counts and widths the logic cannot serve
    if (BOOT_CYCLES < 2 || PLL_CYCLES < 2)
    begin
        $error("bmsc_boot_sleep_ctrl counts too small");
    end
    if (DIV_W < 1 || WAKE_W < 1)
    begin
        $error("bmsc_boot_sleep_ctrl widths too small");
    end

    bmsc_state_e state_q;
    logic resetPinPrev_q;
    logic timerStart;
    logic [TW-1:0] timerCount;
    logic timerBusy;
    logic timerDone;

    logic wakeHit;
    logic releaseEdge;

    // decode the strap pair into a mode
    function automatic bmsc_mode_e decodeStrap(input logic [1:0] s);
        case (s)
            `BMSC_STRAP_PAR: decodeStrap = BMSC_MODE_PARALLEL; // R3
            `BMSC_STRAP_FSP: decodeStrap = BMSC_MODE_FAST_SERIAL; // R3
            `BMSC_STRAP_SPI: decodeStrap = BMSC_MODE_SPI; // R3
            default: decodeStrap = BMSC_MODE_STANDALONE; // R3
        endcase
    endfunction

    // the release edge of the reset pin is when straps are caught
    assign releaseEdge = activeLowResetPin_n && !resetPinPrev_q;

    // only enabled sources count; any one wakes the cpu
    assign wakeHit = |(wakeEnable & wakeEvent); // R16

    // timer loads for boot after pin release, or for pll lock on wake
    always_comb
    begin
        timerStart = 1'b0;
        timerCount = '0;

        if (releaseEdge)
        begin
            timerStart = 1'b1;
            timerCount = TW'(BOOT_CYCLES); // R4
        end
        else if (state_q == BMSC_ST_SLEEP && wakeHit)
        begin
            timerStart = 1'b1;
            timerCount = TW'(PLL_CYCLES); // R18
        end
    end

    bmsc_cycle_timer #(
        .WIDTH(TW)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(timerStart),
        .count(timerCount),
        .busy(timerBusy),
        .done(timerDone)
    );

    // previous reset pin level; held low while pin is low
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            resetPinPrev_q <= 1'b0;
        else
            resetPinPrev_q <= activeLowResetPin_n;
    end

    // strap capture at the release edge only, so later pin use is free
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bootMode <= BMSC_MODE_PARALLEL;
            clockRateSel <= 1'b1;
        end
        else if (releaseEdge)
        begin
            bootMode <= decodeStrap(gpioIn[31:30]); // R2 R5
            clockRateSel <= clockRateStrap; // R1
        end
    end

    // main sequencer; a low reset pin forces boot again at any time
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            state_q <= BMSC_ST_BOOT;
        else if (!activeLowResetPin_n)
            state_q <= BMSC_ST_BOOT; // R19
        else
        begin
            case (state_q)
                BMSC_ST_BOOT:
                    if (timerDone)
                        state_q <= BMSC_ST_RUN; // R4 R7
                BMSC_ST_RUN:
                    if (pwrCtrlWe && sleepEnableWr)
                        state_q <= BMSC_ST_SLEEP; // R13
                BMSC_ST_SLEEP:
                    if (wakeHit)
                        state_q <= BMSC_ST_WAKE; // R16 R20
                BMSC_ST_WAKE:
                    if (timerDone)
                        state_q <= BMSC_ST_RUN; // R18
                default:
                    state_q <= BMSC_ST_BOOT;
            endcase
        end
    end

    // boot and load-ready flags
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bootDone <= 1'b0;
            loadReady <= 1'b0;
        end
        else if (!activeLowResetPin_n)
        begin
            bootDone <= 1'b0;
            loadReady <= 1'b0;
        end
        else if (state_q == BMSC_ST_BOOT && timerDone)
        begin
            bootDone <= 1'b1; // R4
            loadReady <= 1'b1; // R7
        end
    end

    // only the strapped port comes up, and only after boot; idle until
    // the host speaks (line speeds are held by the port blocks themselves)
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            parallelHostPortEn <= 1'b0;
            fastSerialPortEn <= 1'b0;
            spiSlavePortEn <= 1'b0;
            coprocIdle <= 1'b0;
        end
        else if (!bootDone)
        begin
            parallelHostPortEn <= 1'b0;
            fastSerialPortEn <= 1'b0;
            spiSlavePortEn <= 1'b0;
            coprocIdle <= 1'b0;
        end
        else
        begin
            parallelHostPortEn <= (bootMode == BMSC_MODE_PARALLEL); // R6 R8
            fastSerialPortEn <= (bootMode == BMSC_MODE_FAST_SERIAL); // R6 R8
            spiSlavePortEn <= (bootMode == BMSC_MODE_SPI); // R6 R8
            if (bootMode == BMSC_MODE_STANDALONE)
                coprocIdle <= 1'b0;
            else if (portActivity)
                coprocIdle <= 1'b0; // R6
            else if (!parallelHostPortEn && !fastSerialPortEn
                     && !spiSlavePortEn)
                coprocIdle <= 1'b1; // R6
        end
    end

    // pin setup; during boot all pins are inputs so straps read clean,
    // and sleep freezes the setup instead of recomputing it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            gpioOe_n <= '1;
            gpioOut <= '0;
            debugUartEn <= 1'b0;
            otgIsPeripheral <= 1'b1;
            otherPortsPeripheral <= 3'h7;
        end
        else if (!bootDone)
        begin
            gpioOe_n <= '1; // R5
            gpioOut <= '0;
            debugUartEn <= 1'b0;
        end
        else if (state_q == BMSC_ST_RUN)
        begin
            gpioOe_n <= appGpioOe_n; // R5 R11
            gpioOut <= appGpioOut;
            otherPortsPeripheral <= 3'h7; // R11
            if (bootMode == BMSC_MODE_STANDALONE)
            begin
                gpioOe_n[`BMSC_PIN_EEP_SCL] <= 1'b0; // R9
                gpioOe_n[`BMSC_PIN_EEP_SDA] <= 1'b0; // R9
                gpioOe_n[`BMSC_PIN_UART_TX] <= 1'b0; // R9
                gpioOe_n[`BMSC_PIN_UART_RX] <= 1'b1; // R9
                gpioOe_n[`BMSC_PIN_OTG_ID] <= 1'b1; // R10
                debugUartEn <= 1'b1; // R9
                otgIsPeripheral <= gpioIn[`BMSC_PIN_OTG_ID]; // R10
            end
            else
                debugUartEn <= 1'b0;
        end
        // sleep and wake keep every pin as it was
    end

    // cpu speed divider; peripherals keep their own clocks
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cpuSpeedDiv <= DIV_W'(`BMSC_CPU_DIV_RESET);
        else if (!activeLowResetPin_n)
            cpuSpeedDiv <= DIV_W'(`BMSC_CPU_DIV_RESET);
        else if (cpuSpeedWe && state_q == BMSC_ST_RUN)
            cpuSpeedDiv <= cpuSpeedWr; // R12
    end

    // analog enables and cpu gate follow the state
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sleepActive <= 1'b0;
            cpuSuspended <= 1'b1;
            crystalDriveEn <= 1'b1;
            pllEn <= 1'b1;
            boosterEn <= 1'b1;
            transceiverEn <= 1'b1;
        end
        else
        begin
            sleepActive <= (state_q == BMSC_ST_SLEEP); // R13
            cpuSuspended <= (state_q != BMSC_ST_RUN); // R16 R20
            crystalDriveEn <= (state_q != BMSC_ST_SLEEP); // R15 R20
            pllEn <= (state_q != BMSC_ST_SLEEP); // R15 R20
            boosterEn <= (state_q != BMSC_ST_SLEEP); // R15
            transceiverEn <= (state_q != BMSC_ST_SLEEP); // R15
        end
    end

    // charge pump follows firmware; a sleep without switching it off
    // leaves the bus near supply, so hardware does not override it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pumpEn <= 1'b0;
        else
            pumpEn <= pumpEnableIn; // R17
    end

    // memory address pins forced low while asleep
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            memAddrOut <= '0;
        else if (state_q == BMSC_ST_SLEEP)
            memAddrOut <= '0; // R14
        else
            memAddrOut <= memAddrIn;
    end

    // timer busy is only informative here
    logic unusedBusy;
    assign unusedBusy = timerBusy;

endmodule // bmsc_boot_sleep_ctrl

//--- hw/bmsc_regs.svh
// offsets, field positions and timing counts for boot mode and sleep control
`ifndef BMSC_REGS_SVH
`define BMSC_REGS_SVH

`define BMSC_CLK_MHZ 50
`define BMSC_BOOT_TIME_US 3000
`define BMSC_BOOT_CYC ((`BMSC_BOOT_TIME_US * `BMSC_CLK_MHZ))
`define BMSC_PLL_LOCK_US 200
`define BMSC_PLL_CYC ((`BMSC_PLL_LOCK_US * `BMSC_CLK_MHZ))
`define BMSC_SRC_NORMAL_MHZ 12
`define BMSC_STRAP_PAR 2'h0
`define BMSC_STRAP_FSP 2'h1
`define BMSC_STRAP_SPI 2'h2
`define BMSC_STRAP_ALONE 2'h3
`define BMSC_SLEEP_BIT 1
`define BMSC_CPU_SPEED_ADDR 16'hc008
`define BMSC_PWR_CTRL_ADDR 16'hc00a
`define BMSC_OTG_CTRL_ADDR 16'hc098
`define BMSC_PIN_EEP_SCL 30
`define BMSC_PIN_EEP_SDA 31
`define BMSC_PIN_UART_TX 27
`define BMSC_PIN_UART_RX 28
`define BMSC_PIN_OTG_ID 29
`define BMSC_CPU_DIV_RESET 4'h0

`endif

//--- hw/bmsc_pkg.sv
// types for boot mode and sleep control
package bmsc_pkg;
    typedef enum logic [1:0] {
        BMSC_MODE_PARALLEL,
        BMSC_MODE_FAST_SERIAL,
        BMSC_MODE_SPI,
        BMSC_MODE_STANDALONE
    } bmsc_mode_e;

    typedef enum {
        BMSC_ST_BOOT,
        BMSC_ST_RUN,
        BMSC_ST_SLEEP,
        BMSC_ST_WAKE
    } bmsc_state_e;
endpackage

//--- hw/bmsc_cycle_timer.sv
// down-counter that raises done when a loaded count runs out
`timescale 1ns/1ns
module bmsc_cycle_timer #(
    parameter int WIDTH = 20
) (
    input wire logic sys_clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic start, // load count and begin
    input wire logic [WIDTH-1:0] count, // cycles to run
    output logic busy, // counting
    output logic done // one-cycle pulse at expiry
);
    logic [WIDTH-1:0] cnt_q;

    // refuse a width the counter cannot serve
    if (WIDTH < 2)
        $error("bmsc_cycle_timer width too small");

    // counter; a restart while busy reloads, so late events extend the wait
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (start)
        begin
            cnt_q <= count;
            busy <= 1'b1;
            done <= 1'b0;
        end
        else if (busy)
        begin
            cnt_q <= cnt_q - 1'b1;
            done <= (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
            busy <= (cnt_q != {{(WIDTH-1){1'b0}}, 1'b1});
        end
        else
            done <= 1'b0;
    end
endmodule // bmsc_cycle_timer

//--- tb/bmsc_boot_sleep_ctrl_assertions.sv
// assertion checker for boot mode and sleep control
`timescale 1ns/1ns
module bmsc_boot_sleep_ctrl_assertions #(
    parameter int BOOT_CYCLES = 20, // boot time in cycles
    parameter int PLL_CYCLES = 10, // pll lock time in cycles
    parameter int WAKE_W = 8 // wakeup sources
) (
    input wire logic sys_clk, // clock
    input wire logic rst, // reset
    input wire logic activeLowResetPin_n, // reset pin
    input wire logic clockRateStrap, // rate strap
    input wire logic [31:0] gpioIn, // pin levels
    input wire logic sleepEnableWr, // sleep bit
    input wire logic pwrCtrlWe, // sleep strobe
    input wire logic [WAKE_W-1:0] wakeEnable, // wake enables
    input wire logic [WAKE_W-1:0] wakeEvent, // wake events
    input bmsc_pkg::bmsc_mode_e bootMode, // mode
    input wire logic clockRateSel, // rate
    input wire logic bootDone, // boot over
    input wire logic loadReady, // load open
    input wire logic parallelHostPortEn, // port on
    input wire logic fastSerialPortEn, // port on
    input wire logic spiSlavePortEn, // port on
    input wire logic [31:0] gpioOe_n, // pin enables
    input wire logic debugUartEn, // uart
    input wire logic sleepActive, // asleep
    input wire logic cpuSuspended, // cpu gated
    input wire logic crystalDriveEn, // crystal
    input wire logic pllEn, // pll
    input wire logic boosterEn, // booster
    input wire logic transceiverEn, // transceivers
    input wire logic [15:0] memAddrOut // address pins
);
    import bmsc_pkg::*;
    int bootCnt_q;
    int wakeCnt_q;
    logic waking_q;
    wire logic [1:0] strapPins = gpioIn[31:30];
    wire logic wakeHit = |(wakeEnable & wakeEvent);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // cycles since the pin let go, frozen once boot ends
    always_ff @(posedge sys_clk)
    begin
        if (rst || !activeLowResetPin_n)
            bootCnt_q <= 0;
        else if (!bootDone)
            bootCnt_q <= bootCnt_q + 1;
    end
    // cycles from leaving sleep to cpu clock return; a pin reset aborts
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            waking_q <= 1'b0;
            wakeCnt_q <= 0;
        end
        else
        begin
            waking_q <= activeLowResetPin_n &&
                (sleepActive || (waking_q && cpuSuspended));
            wakeCnt_q <= (waking_q && !sleepActive) ? wakeCnt_q + 1 : 0;
        end
    end
    sequence sleepReq;
        pwrCtrlWe && sleepEnableWr && !cpuSuspended && !sleepActive;
    endsequence
    sequence allOff;
        sleepActive && !crystalDriveEn && !pllEn && !boosterEn &&
            !transceiverEn;
    endsequence
    a_boot_early: assert property ($rose(bootDone) |->
        bootCnt_q >= BOOT_CYCLES) else $error("boot ended early");
    a_boot_bound: assert property (activeLowResetPin_n && !bootDone |->
        bootCnt_q <= BOOT_CYCLES + 3) else $error("boot too long");
    a_pin_clears: assert property (!activeLowResetPin_n [*2] |->
        !bootDone && !loadReady) else $error("pin reset ignored");
    a_load_open: assert property ($rose(bootDone) |->
        $rose(loadReady)) else $error("load not opened with boot");
    a_mode_strap: assert property ($rose(activeLowResetPin_n) |=>
        bootMode == $past(strapPins)) else $error("wrong boot mode");
    a_rate_strap: assert property ($rose(activeLowResetPin_n) |=>
        clockRateSel == $past(clockRateStrap)) else $error("wrong rate");
    a_port_select: assert property ($rose(bootDone) |=>
        {spiSlavePortEn, fastSerialPortEn, parallelHostPortEn} ==
        (bootMode == BMSC_MODE_STANDALONE ? 3'h0 : 3'h1 << bootMode))
        else $error("wrong port enabled");
    a_alone_pins: assert property ($rose(bootDone) &&
        bootMode == BMSC_MODE_STANDALONE |=> debugUartEn &&
        gpioOe_n[31:27] == 5'h06) else $error("standalone pins wrong");
    a_sleep_entry: assert property (sleepReq |=> ##1 allOff)
        else $error("sleep not entered");
    a_sleep_hold: assert property (sleepActive |->
        memAddrOut == 16'h0 && cpuSuspended) else $error("sleep state wrong");
    a_gpio_frozen: assert property (sleepActive && $past(sleepActive) |->
        $stable(gpioOe_n)) else $error("pins moved in sleep");
    a_wake_ignore: assert property ((sleepActive && !wakeHit &&
        activeLowResetPin_n) [*2] |=> sleepActive) else $error("woke early");
    a_wake_start: assert property (sleepActive && wakeHit |->
        ##[1:3] !sleepActive) else $error("wake event lost");
    a_wake_bound: assert property (wakeCnt_q <= PLL_CYCLES + 4)
        else $error("resume too slow");
    a_wake_gated: assert property ($fell(cpuSuspended) && waking_q |->
        wakeCnt_q >= PLL_CYCLES) else $error("cpu ran before pll lock");
endmodule // bmsc_boot_sleep_ctrl_assertions

bind bmsc_boot_sleep_ctrl bmsc_boot_sleep_ctrl_assertions #(
    .BOOT_CYCLES(BOOT_CYCLES), .PLL_CYCLES(PLL_CYCLES), .WAKE_W(WAKE_W)
) chk (.sys_clk, .rst, .activeLowResetPin_n, .clockRateStrap, .gpioIn,
    .sleepEnableWr, .pwrCtrlWe, .wakeEnable, .wakeEvent, .bootMode,
    .clockRateSel, .bootDone, .loadReady, .parallelHostPortEn,
    .fastSerialPortEn, .spiSlavePortEn, .gpioOe_n, .debugUartEn,
    .sleepActive, .cpuSuspended, .crystalDriveEn, .pllEn, .boosterEn,
    .transceiverEn, .memAddrOut);

//--- tb/bmsc_host_model.sv
// host processor model: reset pin, boot straps and port traffic
`timescale 1ns/1ns
module bmsc_host_model (
    input wire logic sys_clk, // system clock
    input wire logic loadReady, // device open for code
    output logic pinRst_n, // reset pin, low = reset
    output logic [1:0] strapPins, // boot strap levels
    output logic clockStrap, // clock rate strap
    output logic portActivity // traffic on chosen port
);
    // pin starts low, as at power-up
    initial
    begin
        pinRst_n = 1'b0;
        strapPins = 2'h0;
        clockStrap = 1'b1;
        portActivity = 1'b0;
    end
    // 70 cycles covers sixteen 12 MHz periods with margin
    task automatic reset_pulse(input logic [1:0] mode, input logic rate);
        @(posedge sys_clk) pinRst_n <= 1'b0;
        strapPins <= mode;
        clockStrap <= rate;
        repeat (70) @(posedge sys_clk);
        pinRst_n <= 1'b1;
    endtask
    // resistors keep whatever level is set here
    task automatic set_straps(input logic [1:0] lvl);
        @(posedge sys_clk) strapPins <= lvl;
    endtask
    // a slow host lags; none talks before loading is open
    task automatic talk(input int lag);
        repeat (lag) @(posedge sys_clk);
        while (loadReady !== 1'b1)
            @(posedge sys_clk);
        @(posedge sys_clk) portActivity <= 1'b1;
        @(posedge sys_clk) portActivity <= 1'b0;
    endtask
endmodule // bmsc_host_model

//--- tb/bmsc_boot_sleep_ctrl_test.sv
// self-checking bench for boot mode and sleep control
`timescale 1ns/1ns
module bmsc_boot_sleep_ctrl_test;
    import bmsc_pkg::*;
    localparam int BOOT = 20;
    localparam int PLL = 10;
    logic sys_clk, rst, activeLowResetPin_n, clockRateStrap, portActivity;
    logic cpuSpeedWe, sleepEnableWr, pwrCtrlWe, pumpEnableIn, pumpEn;
    logic [1:0] strapPins;
    logic [29:0] gpioRest;
    logic [31:0] gpioIn, appGpioOe_n, appGpioOut, gpioOe_n, gpioOut;
    logic [3:0] cpuSpeedWr, cpuSpeedDiv;
    logic [7:0] wakeEnable, wakeEvent;
    logic [15:0] memAddrIn, memAddrOut;
    logic [2:0] otherPortsPeripheral, ports;
    bmsc_mode_e bootMode;
    logic clockRateSel, bootDone, loadReady, parallelHostPortEn;
    logic fastSerialPortEn, spiSlavePortEn, coprocIdle, debugUartEn;
    logic otgIsPeripheral, sleepActive, cpuSuspended, crystalDriveEn;
    logic pllEn, boosterEn, transceiverEn;
    int fails, compares, cycles;
    assign gpioIn = {strapPins, gpioRest};
    assign ports = {spiSlavePortEn, fastSerialPortEn, parallelHostPortEn};
    bmsc_boot_sleep_ctrl #(.BOOT_CYCLES(BOOT), .PLL_CYCLES(PLL)) uut (
        .sys_clk, .rst, .activeLowResetPin_n, .clockRateStrap, .gpioIn,
        .appGpioOe_n, .appGpioOut, .cpuSpeedWr, .cpuSpeedWe, .sleepEnableWr,
        .pwrCtrlWe, .wakeEnable, .wakeEvent, .pumpEnableIn, .portActivity,
        .memAddrIn, .bootMode, .clockRateSel, .bootDone, .loadReady,
        .parallelHostPortEn, .fastSerialPortEn, .spiSlavePortEn, .coprocIdle,
        .gpioOe_n, .gpioOut, .debugUartEn, .otgIsPeripheral,
        .otherPortsPeripheral, .cpuSpeedDiv, .sleepActive, .cpuSuspended,
        .crystalDriveEn, .pllEn, .boosterEn, .transceiverEn, .pumpEn,
        .memAddrOut);
    bmsc_host_model hm (.sys_clk, .loadReady, .pinRst_n(activeLowResetPin_n),
        .strapPins, .clockStrap(clockRateStrap), .portActivity);
    // compare one value and count it
    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // boot with one strap setting, judge mode, ports and pins
    task automatic test_boot(input logic [1:0] mode, input logic rate);
        int n;
        hm.reset_pulse(mode, rate);
        n = 0;
        while (loadReady !== 1'b1 && n < 100)
        begin
            @(negedge sys_clk);
            n++;
        end
        check("boot time", n >= BOOT + 1 && n <= BOOT + 4, 1);
        check("boot mode", bootMode, mode);
        check("rate sel", clockRateSel, rate);
        repeat (3) @(negedge sys_clk);
        check("ports", ports, mode == 2'h3 ? 3'h0 : 3'h1 << mode);
        if (mode == 2'h3)
        begin
            check("pin dirs", gpioOe_n, 32'h37ffffff);
            check("uart", debugUartEn, 1);
            check("usb roles", otherPortsPeripheral, 3'h7);
            @(posedge sys_clk) gpioRest[29] <= 1'b0;
            repeat (3) @(negedge sys_clk);
            check("otg host", otgIsPeripheral, 0);
            @(posedge sys_clk) gpioRest[29] <= 1'b1;
            repeat (3) @(negedge sys_clk);
            check("otg periph", otgIsPeripheral, 1);
        end
        else
        begin
            check("idle", coprocIdle, 1);
            hm.talk(mode);
            hm.set_straps(~mode);
            @(posedge sys_clk) appGpioOe_n[31:30] <= 2'h0;
            repeat (3) @(negedge sys_clk);
            check("talking", coprocIdle, 0);
            check("strap oe", gpioOe_n[31:30], 2'h0);
            check("strap out", gpioOut[31:30], 2'h2);
            check("mode kept", bootMode, mode);
            @(posedge sys_clk) appGpioOe_n <= '1;
        end
        $display("boot test %0d done", mode);
    endtask
    // scale the cpu clock while running
    task automatic test_speed;
        @(posedge sys_clk) cpuSpeedWr <= 4'h5;
        cpuSpeedWe <= 1'b1;
        @(posedge sys_clk) cpuSpeedWe <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check("cpu speed", cpuSpeedDiv, 4'h5);
        check("xcvr on", transceiverEn, 1);
        check("pump on", pumpEn, 1);
        check("mem addr run", memAddrOut, 16'h5a5a);
        $display("speed test done");
    endtask
    // sleep, try a disabled source and a refused write, then wake
    task automatic test_sleep;
        int n;
        @(posedge sys_clk) pumpEnableIn <= 1'b0;
        @(posedge sys_clk) pwrCtrlWe <= 1'b1;
        sleepEnableWr <= 1'b1;
        @(posedge sys_clk) pwrCtrlWe <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check("asleep", sleepActive, 1);
        check("xtal pll", {crystalDriveEn, pllEn}, 0);
        check("boost xcvr", {boosterEn, transceiverEn}, 0);
        check("mem addr", memAddrOut, 16'h0);
        check("cpu held", cpuSuspended, 1);
        check("pump off", pumpEn, 0);
        @(posedge sys_clk) appGpioOe_n <= 32'h0;
        wakeEvent <= 8'h01;
        wakeEnable <= 8'h02;
        cpuSpeedWr <= 4'ha;
        cpuSpeedWe <= 1'b1;
        @(posedge sys_clk) cpuSpeedWe <= 1'b0;
        repeat (6) @(negedge sys_clk);
        check("still asleep", sleepActive, 1);
        check("pins frozen", gpioOe_n, 32'h37ffffff);
        @(posedge sys_clk) wakeEnable <= 8'h01;
        n = 0;
        while (cpuSuspended !== 1'b0 && n < 100)
        begin
            @(negedge sys_clk);
            n++;
        end
        check("wake time", n >= PLL && n <= PLL + 6, 1);
        check("pll on", {crystalDriveEn, pllEn}, 2'h3);
        check("speed kept", cpuSpeedDiv, 4'h5);
        repeat (2) @(negedge sys_clk);
        check("pins free", gpioOe_n, 32'h30000000);
        $display("sleep test done");
    endtask
    // free-running clock
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // a run needs under a thousand cycles, so this only trips on a hang
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            end_of_test();
        end
    end
    // main sequence
    initial
    begin
        rst = 1'b1;
        gpioRest = 30'h0;
        appGpioOe_n = '1;
        appGpioOut = 32'h80000000;
        cpuSpeedWr = 4'h0;
        cpuSpeedWe = 1'b0;
        sleepEnableWr = 1'b0;
        pwrCtrlWe = 1'b0;
        wakeEnable = 8'h00;
        wakeEvent = 8'h00;
        pumpEnableIn = 1'b1;
        memAddrIn = 16'h5a5a;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        for (int m = 0; m < 4; m++)
            test_boot(2'(m), m[0]);
        test_speed();
        test_sleep();
        end_of_test();
    end
endmodule // bmsc_boot_sleep_ctrl_test
